// [hw/asc_dev.sv]
// converter end: bus target, configuration and single-shot control
// Notes on behaviour
// - never drives the clock line low
// - works with standard and fast-mode controllers
// - strap picks one of three addresses
// - host uses codes 100-111 for single-ended
// - single-ended results stay within 0000h-7FF0h
// - inputs against input three allow negatives
// - single-shot ends, then device powers down
// - host picks the single-shot request interval
// - example host addresses target 1001 000
// - example write configures and sets start flag
// - start accepted only idle; flag reads idle
// - first written byte selects the register
// - host may poll start flag before reading
// - upper byte first, msb first
`timescale 1ns/10ps
module asc_dev #(
	parameter int unsigned US_TICK_CYC = asc_pkg::US_CYC
) (
	// link clock and reset
	input  wire logic        LINK_CLK,
	input  wire logic        RST,
	// bus
	asc_if.dev               BUS,
	// address strap
	input  wire logic [1:0]  ADDR_STRAP,
	// analog front end
	input  wire logic [11:0] ADC_SAMPLE,
	output logic      [2:0]  INPUT_SEL,
	output logic      [2:0]  FULL_SCALE,
	output logic             CONVERTING
);
	logic [1:0]        scl_sync_reg;
	logic [1:0]        sda_sync_reg;
	logic              scl_d_reg;
	logic              sda_d_reg;
	logic [1:0]        strap_m_reg;
	logic [1:0]        strap_s_reg;
	logic [1:0]        strap_cnt_reg;
	logic [6:0]        own_addr_reg;
	asc_pkg::asc_dst_t state_reg;
	logic [3:0]        bit_cnt_reg;
	logic [7:0]        shift_reg;
	logic              rw_reg;
	logic [1:0]        byte_cnt_reg;
	logic [7:0]        ptr_reg;
	logic [7:0]        cfg_hi_reg;
	logic [15:0]       wr_val_reg;
	logic              wr_pulse_reg;
	logic [15:0]       tx_reg;
	logic              acked_reg;
	logic              sda_oe_reg;
	logic [14:0]       cfg_reg;
	logic              busy_reg;
	logic [15:0]       tick_reg;
	logic [12:0]       us_reg;
	logic [11:0]       result_reg;
	logic [11:0]       adc_m_reg;
	logic [11:0]       adc_s_reg;
	logic              scl;
	logic              sda;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_c;
	logic              stop_c;
	logic [7:0]        byte_in;
	logic [15:0]       rd_word;
	logic              start_ok;

	assign scl      = scl_sync_reg[1];
	assign sda      = sda_sync_reg[1];
	assign scl_rise = scl && !scl_d_reg;
	assign scl_fall = !scl && scl_d_reg;
	assign start_c  = scl && scl_d_reg && sda_d_reg && !sda;
	assign stop_c   = scl && scl_d_reg && !sda_d_reg && sda;
	assign byte_in  = {shift_reg[6:0], sda};

	// clock only observed
	// only the data line has a driver here, so no stretching can occur
	assign BUS.dev_sda_o  = 1'b0;
	assign BUS.dev_sda_oe = sda_oe_reg;
	assign INPUT_SEL  = cfg_reg[asc_pkg::CFG_MUX_LSB +: 3];
	assign FULL_SCALE = cfg_reg[asc_pkg::CFG_FS_LSB +: 3];
	assign CONVERTING = busy_reg;

	// oversampled pin synchronisers
	// the link clock outruns fast mode many times over
	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], BUS.scl};
			sda_sync_reg <= {sda_sync_reg[0], BUS.sda};
			scl_d_reg    <= scl;
			sda_d_reg    <= sda;
		end
	end

	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			strap_m_reg   <= 2'h0;
			strap_s_reg   <= 2'h0;
			strap_cnt_reg <= 2'h0;
			own_addr_reg  <= asc_pkg::ADDR_STRAP0;
		end
		else
		begin
			strap_m_reg <= ADDR_STRAP;
			strap_s_reg <= strap_m_reg;
			if (strap_cnt_reg != 2'h3)
			begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
				if (strap_cnt_reg == 2'h2)
				begin
					if (strap_s_reg == 2'h0)
						own_addr_reg <= asc_pkg::ADDR_STRAP0;
					else if (strap_s_reg == 2'h1)
						own_addr_reg <= asc_pkg::ADDR_STRAP1;
					else
						own_addr_reg <= asc_pkg::ADDR_STRAP2;
				end
			end
		end
	end

	// flag is what a poll sees
	assign rd_word = (ptr_reg == asc_pkg::PTR_CFG) ?
		{!busy_reg, cfg_reg} : {result_reg, asc_pkg::DATA_PAD};

	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg    <= asc_pkg::D_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			rw_reg       <= 1'b0;
			byte_cnt_reg <= 2'h0;
			ptr_reg      <= asc_pkg::PTR_DATA;
			cfg_hi_reg   <= 8'h00;
			wr_val_reg   <= 16'h0000;
			wr_pulse_reg <= 1'b0;
			tx_reg       <= 16'h0000;
			acked_reg    <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end
		else
		begin
			wr_pulse_reg <= 1'b0;
			if (start_c)
			begin
				state_reg    <= asc_pkg::D_ADDR;
				bit_cnt_reg  <= 4'h0;
				byte_cnt_reg <= 2'h0;
				sda_oe_reg   <= 1'b0;
			end
			else if (stop_c)
			begin
				state_reg  <= asc_pkg::D_IDLE;
				sda_oe_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					asc_pkg::D_ADDR:
						if (scl_rise)
						begin
							shift_reg   <= byte_in;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7)
							begin
								if (shift_reg[6:0] == own_addr_reg)
								begin
									rw_reg    <= sda;
									state_reg <= asc_pkg::D_AKW;
								end
								else
									state_reg <= asc_pkg::D_IDLE;
							end
						end
					asc_pkg::D_WDAT:
						if (scl_rise)
						begin
							shift_reg   <= byte_in;
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == 4'h7)
							begin
								state_reg <= asc_pkg::D_AKW;
								if (byte_cnt_reg != 2'h3)
									byte_cnt_reg <= byte_cnt_reg + 2'h1;
								if (byte_cnt_reg == 2'h0)
									ptr_reg <= byte_in;
								else if (byte_cnt_reg == 2'h1)
									cfg_hi_reg <= byte_in;
								else if (byte_cnt_reg == 2'h2 &&
									ptr_reg == asc_pkg::PTR_CFG)
								begin
									wr_val_reg   <= {cfg_hi_reg, byte_in};
									wr_pulse_reg <= 1'b1;
								end
							end
						end
					asc_pkg::D_AKW:
						if (scl_fall)
						begin
							sda_oe_reg <= 1'b1;
							state_reg  <= asc_pkg::D_AKD;
						end
					asc_pkg::D_AKD:
						if (scl_fall)
						begin
							bit_cnt_reg <= 4'h0;
							if (rw_reg)
							begin
								tx_reg     <= rd_word;
								sda_oe_reg <= !rd_word[15];
								state_reg  <= asc_pkg::D_RDAT;
							end
							else
							begin
								sda_oe_reg <= 1'b0;
								state_reg  <= asc_pkg::D_WDAT;
							end
						end
					asc_pkg::D_RDAT:
						if (scl_rise)
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						else if (scl_fall)
						begin
							if (bit_cnt_reg == 4'h8)
							begin
								sda_oe_reg <= 1'b0;
								acked_reg  <= 1'b0;
								state_reg  <= asc_pkg::D_RAK;
							end
							else
							begin
								tx_reg     <= {tx_reg[14:0], tx_reg[15]};
								sda_oe_reg <= !tx_reg[14];
							end
						end
					asc_pkg::D_RAK:
						if (scl_rise)
						begin
							if (sda)
								state_reg <= asc_pkg::D_IDLE;
							else
								acked_reg <= 1'b1;
						end
						else if (scl_fall && acked_reg)
						begin
							bit_cnt_reg <= 4'h0;
							tx_reg      <= {tx_reg[14:0], tx_reg[15]};
							sda_oe_reg  <= !tx_reg[14];
							state_reg   <= asc_pkg::D_RDAT;
						end
					default:
						sda_oe_reg <= 1'b0;
				endcase
			end
		end
	end

	assign start_ok = wr_pulse_reg && !busy_reg &&
		(wr_val_reg[asc_pkg::CFG_OS] || !wr_val_reg[asc_pkg::CFG_MODE]);

	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
			cfg_reg <= asc_pkg::CFG_RESET[14:0];
		else if (wr_pulse_reg)
			cfg_reg <= wr_val_reg[14:0];
	end

	// sample is held steady by the front end while converting
	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			adc_m_reg <= 12'h000;
			adc_s_reg <= 12'h000;
		end
		else
		begin
			adc_m_reg <= ADC_SAMPLE;
			adc_s_reg <= adc_m_reg;
		end
	end

	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			busy_reg   <= 1'b0;
			tick_reg   <= 16'h0000;
			us_reg     <= 13'h0000;
			result_reg <= 12'h000;
		end
		else if (start_ok)
		begin
			busy_reg <= 1'b1;
			tick_reg <= 16'h0000;
			us_reg   <= asc_pkg::conv_us(
				wr_val_reg[asc_pkg::CFG_RATE_LSB +: 3]);
		end
		else if (busy_reg)
		begin
			if (tick_reg == 16'(US_TICK_CYC - 1))
			begin
				tick_reg <= 16'h0000;
				if (us_reg == 13'h0001)
				begin
					if (cfg_reg[asc_pkg::CFG_MUX_SE] && adc_s_reg[11])
						result_reg <= 12'h000;
					else
						result_reg <= adc_s_reg;
					if (cfg_reg[asc_pkg::CFG_MODE])
						busy_reg <= 1'b0;
					else
						us_reg <= asc_pkg::conv_us(
							cfg_reg[asc_pkg::CFG_RATE_LSB +: 3]);
				end
				else
					us_reg <= us_reg - 13'h0001;
			end
			else
				tick_reg <= tick_reg + 16'h0001;
		end
	end
endmodule : asc_dev

// [hw/asc_pkg.sv]
// shared constants and types for the single-shot converter link
package asc_pkg;
	// target addresses selected by the strap (1001 000 for strap 0)
	localparam logic [6:0]  ADDR_STRAP0  = 7'h48;
	localparam logic [6:0]  ADDR_STRAP1  = 7'h49;
	localparam logic [6:0]  ADDR_STRAP2  = 7'h4A;
	// register pointer values
	localparam logic [7:0]  PTR_DATA     = 8'h00;
	localparam logic [7:0]  PTR_CFG      = 8'h01;
	// configuration layout and values
	localparam logic [15:0] CFG_RESET    = 16'h8583;
	localparam logic [15:0] CFG_EXAMPLE  = 16'h85C3;
	localparam int          CFG_OS       = 15;
	localparam int          CFG_MUX_SE   = 14;
	localparam int          CFG_MUX_LSB  = 12;
	localparam int          CFG_FS_LSB   = 9;
	localparam int          CFG_MODE     = 8;
	localparam int          CFG_RATE_LSB = 5;
	localparam logic [3:0]  DATA_PAD     = 4'h0;
	// link-side timing: microsecond prescaler on the 6 ns link clock
	localparam int          LINK_PERIOD_PS = 6000;
	localparam int          US_PS          = 1000000;
	localparam int          US_CYC =
		(US_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
	// host side: fast-mode bus clock derived from the 50 MHz clock
	localparam int          SYS_PERIOD_NS  = 20;
	localparam int          SCL_KHZ        = 400;
	localparam int          SCL_QTR_NS     = 1000000 / (SCL_KHZ * 4);
	localparam logic [5:0]  QTR_CYC = 6'((SCL_QTR_NS + SYS_PERIOD_NS - 1)
		/ SYS_PERIOD_NS);

	// device link states
	typedef enum logic [6:0] {
		D_IDLE = 7'h01,
		D_ADDR = 7'h02,
		D_AKW  = 7'h04,
		D_AKD  = 7'h08,
		D_WDAT = 7'h10,
		D_RDAT = 7'h20,
		D_RAK  = 7'h40
	} asc_dst_t;

	// host frame states
	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BIT   = 4'h4,
		H_STOP  = 4'h8
	} asc_hst_t;

	// host command kinds
	typedef enum logic [2:0] {
		K_SET_PTR  = 3'h0,
		K_WR_REG   = 3'h1,
		K_START    = 3'h2,
		K_START_SE = 3'h3,
		K_READ     = 3'h4
	} asc_kind_t;

	// conversion time in microseconds, rounded up, per rate code
	function automatic logic [12:0] conv_us(input logic [2:0] rate);
		case (rate)
			3'h0:    conv_us = 13'd7813;
			3'h1:    conv_us = 13'd4000;
			3'h2:    conv_us = 13'd2041;
			3'h3:    conv_us = 13'd1087;
			3'h4:    conv_us = 13'd625;
			3'h5:    conv_us = 13'd417;
			default: conv_us = 13'd304;
		endcase
	endfunction : conv_us
endpackage : asc_pkg

// [hw/asc_if.sv]
// two-wire bus joining host and converter, open-drain resolved here
`timescale 1ns/10ps
interface asc_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// pulled high unless someone drives low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) ||
		(dev_sda_oe && !dev_sda_o));

	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input  scl,
		input  sda
	);
	modport dev (
		output dev_sda_o,
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface : asc_if

// [hw/asc_host.sv]
// host end: bus controller making the clock and running frames
`timescale 1ns/10ps
module asc_host (
	// system clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	// bus
	asc_if.host                    BUS,
	// command
	input  wire logic              CMD_VALID,
	output logic                   CMD_READY,
	input  wire asc_pkg::asc_kind_t CMD_KIND,
	input  wire logic [6:0]        CMD_ADDR,
	input  wire logic [7:0]        CMD_PTR,
	input  wire logic [15:0]       CMD_DATA,
	// response
	output logic                   RSP_VALID,
	output logic      [15:0]       RSP_DATA,
	output logic                   RSP_NACK,
	output logic                   CONV_IDLE
);
	asc_pkg::asc_hst_t state_reg;
	logic [5:0]        q_cnt_reg;
	logic [1:0]        ph_reg;
	logic [3:0]        bit_reg;
	logic [1:0]        byte_reg;
	logic [1:0]        last_reg;
	logic              rd_reg;
	logic [31:0]       tx_reg;
	logic [15:0]       rx_reg;
	logic              nack_reg;
	logic              scl_oe_reg;
	logic              sda_oe_reg;
	logic [7:0]        ptr_seen_reg;
	logic [7:0]        ptr_sent_reg;
	logic [7:0]        rd_ptr_reg;
	logic [1:0]        sda_sync_reg;
	logic              tick;
	logic              sending;
	logic              accept;
	logic [15:0]       c_word;
	logic [7:0]        c_ptr;
	logic [1:0]        c_last;
	logic              c_rd;

	assign BUS.host_scl_o  = 1'b0;
	assign BUS.host_sda_o  = 1'b0;
	assign BUS.host_scl_oe = scl_oe_reg;
	assign BUS.host_sda_oe = sda_oe_reg;
	assign tick    = q_cnt_reg == asc_pkg::QTR_CYC - 6'h01;
	assign sending = !(rd_reg && byte_reg != 2'h0);
	assign accept  = CMD_VALID && CMD_READY;

	always_comb
	begin
		c_word = CMD_DATA;
		c_ptr  = CMD_PTR;
		c_last = 2'h3;
		c_rd   = 1'b0;
		case (CMD_KIND)
			asc_pkg::K_SET_PTR:
				c_last = 2'h1;
			asc_pkg::K_START:
			begin
				c_ptr = asc_pkg::PTR_CFG;
				c_word[asc_pkg::CFG_OS] = 1'b1;
			end
			asc_pkg::K_START_SE:
			begin
				c_ptr = asc_pkg::PTR_CFG;
				c_word[asc_pkg::CFG_OS] = 1'b1;
				c_word[asc_pkg::CFG_MUX_SE] = 1'b1;
			end
			asc_pkg::K_READ:
			begin
				c_last = 2'h2;
				c_rd   = 1'b1;
			end
			default:
				c_last = 2'h3;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			sda_sync_reg <= 2'h3;
		else
			sda_sync_reg <= {sda_sync_reg[0], BUS.sda};
	end

	// quarter-period divider; bus clock runs only inside frames
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			q_cnt_reg <= 6'h00;
		else if (state_reg == asc_pkg::H_IDLE || tick)
			q_cnt_reg <= 6'h00;
		else
			q_cnt_reg <= q_cnt_reg + 6'h01;
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg    <= asc_pkg::H_IDLE;
			ph_reg       <= 2'h0;
			bit_reg      <= 4'h0;
			byte_reg     <= 2'h0;
			last_reg     <= 2'h0;
			rd_reg       <= 1'b0;
			tx_reg       <= 32'h00000000;
			rx_reg       <= 16'h0000;
			nack_reg     <= 1'b0;
			scl_oe_reg   <= 1'b0;
			sda_oe_reg   <= 1'b0;
			ptr_seen_reg <= asc_pkg::PTR_DATA;
			ptr_sent_reg <= asc_pkg::PTR_DATA;
			rd_ptr_reg   <= asc_pkg::PTR_DATA;
			CMD_READY    <= 1'b0;
			RSP_VALID    <= 1'b0;
			RSP_DATA     <= 16'h0000;
			RSP_NACK     <= 1'b0;
			CONV_IDLE    <= 1'b0;
		end
		else
		begin
			RSP_VALID <= 1'b0;
			case (state_reg)
				asc_pkg::H_IDLE:
				begin
					CMD_READY <= !accept;
					if (accept)
					begin
						tx_reg    <= {CMD_ADDR, c_rd, c_ptr, c_word};
						last_reg  <= c_last;
						rd_reg    <= c_rd;
						rd_ptr_reg <= ptr_seen_reg;
						ptr_sent_reg <= c_ptr;
						nack_reg  <= 1'b0;
						byte_reg  <= 2'h0;
						bit_reg   <= 4'h0;
						ph_reg    <= 2'h0;
						state_reg <= asc_pkg::H_START;
					end
				end
				asc_pkg::H_START:
					if (tick)
					begin
						if (ph_reg == 2'h0)
						begin
							sda_oe_reg <= 1'b1;
							ph_reg     <= 2'h1;
						end
						else
						begin
							scl_oe_reg <= 1'b1;
							ph_reg     <= 2'h0;
							state_reg  <= asc_pkg::H_BIT;
						end
					end
				asc_pkg::H_BIT:
					if (tick)
					begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
							2'h0:
								if (bit_reg == 4'h8)
									sda_oe_reg <= !sending &&
										byte_reg != last_reg;
								else
									sda_oe_reg <= sending && !tx_reg[31];
							2'h1:
								scl_oe_reg <= 1'b0;
							2'h2:
								if (bit_reg == 4'h8)
								begin
									if (sending && sda_sync_reg[1])
										nack_reg <= 1'b1;
								end
								else if (!sending)
									rx_reg <= {rx_reg[14:0], sda_sync_reg[1]};
							default:
							begin
								scl_oe_reg <= 1'b1;
								if (bit_reg == 4'h8)
								begin
									bit_reg  <= 4'h0;
									byte_reg <= byte_reg + 2'h1;
									if (nack_reg || byte_reg == last_reg)
										state_reg <= asc_pkg::H_STOP;
								end
								else
								begin
									bit_reg <= bit_reg + 4'h1;
									if (sending)
										tx_reg <= {tx_reg[30:0], 1'b0};
								end
							end
						endcase
					end
				asc_pkg::H_STOP:
					if (tick)
					begin
						ph_reg <= ph_reg + 2'h1;
						case (ph_reg)
							2'h0:
								sda_oe_reg <= 1'b1;
							2'h1:
								scl_oe_reg <= 1'b0;
							2'h2:
								sda_oe_reg <= 1'b0;
							default:
							begin
								state_reg <= asc_pkg::H_IDLE;
								CMD_READY <= 1'b1;
								RSP_VALID <= 1'b1;
								RSP_DATA  <= rx_reg;
								RSP_NACK  <= nack_reg;
								// a refused frame leaves the far pointer alone
								if (!rd_reg && !nack_reg)
									ptr_seen_reg <= ptr_sent_reg;
								if (rd_reg && !nack_reg &&
									rd_ptr_reg == asc_pkg::PTR_CFG)
									CONV_IDLE <= rx_reg[asc_pkg::CFG_OS];
							end
						endcase
					end
				default:
					state_reg <= asc_pkg::H_IDLE;
			endcase
		end
	end
endmodule : asc_host

// [tb/asc_sva.sv]
// bus-level checks across the host and converter ends
`timescale 1ns/10ps
module asc_sva (
	// clocks and reset
	input wire logic SYS_CLK,
	input wire logic LINK_CLK,
	input wire logic RST,
	// drivers and resolved wires
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	no_stretch_a: assert property (
		@(posedge LINK_CLK) disable iff (RST) !scl |-> host_scl_oe)
		else $error("clock low without host drive");
	dev_drain_a: assert property (
		@(posedge LINK_CLK) disable iff (RST) dev_sda_oe |-> !dev_sda_o)
		else $error("device drives data high");
	// raw clock seen here, so the device lags by its synchroniser
	dev_edge_a: assert property (
		@(posedge LINK_CLK) disable iff (RST) $changed(dev_sda_oe) |-> !scl)
		else $error("device data changed with clock high");
	stop_free_a: assert property (
		@(posedge LINK_CLK) disable iff (RST)
		$rose(sda) && scl |=> !dev_sda_oe [*8])
		else $error("device pulls data after a stop");
	host_drain_a: assert property (
		@(posedge SYS_CLK) disable iff (RST) !host_scl_o && !host_sda_o)
		else $error("host drives a line high");
	start_seq_a: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		$rose(host_sda_oe) && !host_scl_oe |-> ##32 $rose(host_scl_oe))
		else $error("start not followed by clock low");
	scl_low_a: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		$rose(host_scl_oe) |-> ##63 host_scl_oe ##[1:33] !host_scl_oe)
		else $error("clock low phase out of range");
	scl_high_a: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		$fell(host_scl_oe) |-> ##63 !host_scl_oe)
		else $error("clock high phase too short");
	ack_seen_c: cover property (@(posedge LINK_CLK) disable iff (RST)
		$rose(dev_sda_oe));
	start_seen_c: cover property (@(posedge SYS_CLK) disable iff (RST)
		$rose(host_sda_oe) && !host_scl_oe);
	stop_seen_c: cover property (@(posedge LINK_CLK) disable iff (RST)
		$rose(sda) && scl);
endmodule : asc_sva

// [tb/tb.sv]
// bench: host and converter ends joined on the two-wire bus
`timescale 1ns/10ps
module tb;
	logic               SYS_CLK = 1'b0;
	logic               LINK_CLK = 1'b0;
	logic               RST = 1'b0;
	logic [1:0]         strap = 2'h0;
	logic [11:0]        sample = 12'h000;
	logic               cmd_valid = 1'b0;
	asc_pkg::asc_kind_t cmd_kind = asc_pkg::K_SET_PTR;
	logic [6:0]         cmd_addr = 7'h00;
	logic [7:0]         cmd_ptr = 8'h00;
	logic [15:0]        cmd_data = 16'h0000;
	logic               cmd_ready;
	logic               rsp_valid;
	logic               rsp_nack;
	logic               conv_idle;
	logic               converting;
	logic [15:0]        rsp_data;
	logic [2:0]         in_sel;
	logic [2:0]         fs;
	logic [31:0]        rnd = 32'h0000005F;
	int                 fail_count = 0;
	int                 check_count = 0;
	logic [6:0]         addr_tab [3] = '{asc_pkg::ADDR_STRAP0,
		asc_pkg::ADDR_STRAP1, asc_pkg::ADDR_STRAP2};
	logic [2:0]         mux_tab [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h3};

	always #10 SYS_CLK = ~SYS_CLK;
	// link clock offset so its edges never line up with the host's
	initial
	begin
		#2.7;
		forever #3 LINK_CLK = ~LINK_CLK;
	end

	asc_if bus ();
	asc_host asc_host_i (.SYS_CLK(SYS_CLK), .RST(RST), .BUS(bus),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind),
		.CMD_ADDR(cmd_addr), .CMD_PTR(cmd_ptr), .CMD_DATA(cmd_data),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack),
		.CONV_IDLE(conv_idle));
	asc_dev #(.US_TICK_CYC(2)) asc_dev_i (.LINK_CLK(LINK_CLK), .RST(RST),
		.BUS(bus), .ADDR_STRAP(strap), .ADC_SAMPLE(sample),
		.INPUT_SEL(in_sel), .FULL_SCALE(fs), .CONVERTING(converting));
	asc_sva asc_sva_i (.SYS_CLK(SYS_CLK), .LINK_CLK(LINK_CLK), .RST(RST),
		.host_scl_o(bus.host_scl_o), .host_scl_oe(bus.host_scl_oe),
		.host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
		.dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
		.scl(bus.scl), .sda(bus.sda));

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction : xs

	function automatic logic [15:0] exp_res(input logic [2:0] m,
		input logic [11:0] s);
		int v;
		v = $signed(s);
		if (m[2] && v < 0)
			v = 0;
		exp_res = 16'(v * 16);
	endfunction : exp_res

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic cmd(input asc_pkg::asc_kind_t k, input logic [7:0] p,
		input logic [15:0] d, input logic [6:0] a);
		int n;
		n = 0;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_ptr <= p;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		do
		begin
			@(posedge SYS_CLK);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 9);
		cmd_valid <= 1'b0;
		do
		begin
			@(posedge SYS_CLK);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 9000);
		check("frame done", {15'h0, rsp_valid}, 16'h0001);
	endtask : cmd

	task automatic do_reset(input logic [1:0] s);
		strap <= s;
		RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
	endtask : do_reset

	initial
	begin
		logic [11:0] s;
		logic [2:0]  m;
		int          n;
		for (int i = 2; i >= 0; i--)
		begin
			do_reset(2'(i));
			cmd(asc_pkg::K_SET_PTR, asc_pkg::PTR_CFG, 16'h0000, addr_tab[i]);
			check("own address", {15'h0, rsp_nack}, 16'h0000);
			cmd(asc_pkg::K_SET_PTR, asc_pkg::PTR_DATA, 16'h0000,
				addr_tab[(i + 1) % 3]);
			check("other address", {15'h0, rsp_nack}, 16'h0001);
		end
		// pointer left at config: the refused frame must not move it
		cmd(asc_pkg::K_READ, 8'h00, 16'h0000, addr_tab[0]);
		check("reset config", rsp_data, asc_pkg::CFG_RESET);
		check("reset idle", {15'h0, conv_idle}, 16'h0001);
		cmd(asc_pkg::K_START, asc_pkg::PTR_CFG, 16'h0503, addr_tab[0]);
		cmd(asc_pkg::K_READ, 8'h00, 16'h0000, addr_tab[0]);
		check("busy config", rsp_data, 16'h0503);
		check("busy flag", {15'h0, conv_idle}, 16'h0000);
		n = 0;
		while (converting === 1'b1 && n < 9000)
		begin
			@(posedge SYS_CLK);
			n++;
		end
		check("powered down", {15'h0, converting}, 16'h0000);
		cmd(asc_pkg::K_READ, 8'h00, 16'h0000, addr_tab[0]);
		check("idle config", rsp_data, 16'h8503);
		check("idle flag", {15'h0, conv_idle}, 16'h0001);
		for (int i = 0; i < 5; i++)
		begin
			m = mux_tab[i];
			s = {~(m[2] & m[0]), rnd[10:0]};
			rnd = xs(rnd);
			sample <= s;
			repeat (rnd[3:0]) @(posedge SYS_CLK);
			cmd(m[2] ? asc_pkg::K_START_SE : asc_pkg::K_START,
				asc_pkg::PTR_CFG, asc_pkg::CFG_EXAMPLE | {1'b0, m, 12'h000},
				addr_tab[0]);
			check("input select", {13'h0, in_sel}, {13'h0, m});
			check("full scale", {13'h0, fs}, 16'h0002);
			cmd(asc_pkg::K_SET_PTR, asc_pkg::PTR_DATA, 16'h0000, addr_tab[0]);
			cmd(asc_pkg::K_READ, 8'h00, 16'h0000, addr_tab[0]);
			check("result", rsp_data, exp_res(m, s));
		end
		// continuous mode: flag stays low, so a poll is no use
		cmd(asc_pkg::K_WR_REG, asc_pkg::PTR_CFG, 16'h04C3, addr_tab[0]);
		cmd(asc_pkg::K_READ, 8'h00, 16'h0000, addr_tab[0]);
		check("continuous config", rsp_data, 16'h04C3);
		check("continuous flag", {15'h0, conv_idle}, 16'h0000);
		stop_test();
	end

	// a hung frame ends the run here
	initial
	begin
		repeat (98000) @(posedge SYS_CLK);
		fail_count++;
		stop_test();
	end
endmodule : tb
